// ==== core/ett_pkg.sv ====
// constants for the eight-bit timer control block
//
// Notes on behaviour
// - counter runs when either enable bit set
// - reload mode reloads initial value at terminal
// - one-shot mode halts at terminal count
// - terminal count sets sticky time-out flag
// - writing one clears flag, zero ignored
// - prescale field divides clock by 1,2,4,8
// - prescale and the two interrupt enables survive stop recovery
// - capture interrupt raised when its enable set and demodulation mode selected
// - time-out interrupt raised when its enable set
// - bit zero routes timer to pin
// - mode bit picks transmit or demodulation
package ett_pkg;

    // ****************************************************************
    // bus geometry
    // ****************************************************************
    localparam int          ADDR_W          = 5;
    localparam int          DATA_W          = 32;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 5'h00; // eight_bit_timer_control
    localparam logic [ADDR_W-1:0] OFF_ALT    = 5'h04; // alternate_timer_control
    localparam logic [ADDR_W-1:0] OFF_COMMON = 5'h08; // common_functions_control
    localparam logic [ADDR_W-1:0] OFF_RELOAD = 5'h0c; // initial count value
    localparam logic [ADDR_W-1:0] OFF_COUNT  = 5'h10; // live count, read only
    localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14; // run state, read only

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int          BIT_RUN         = 7;  // timer8_run_enable
    localparam int          BIT_ONE_SHOT    = 6;  // one_shot_or_reload_select
    localparam int          BIT_TIMEOUT     = 5;  // sticky terminal-count flag
    localparam int          BIT_PRE_HI      = 4;  // prescale_select msb
    localparam int          BIT_PRE_LO      = 3;  // prescale_select lsb
    localparam int          BIT_CAP_IE      = 2;  // capture interrupt enable
    localparam int          BIT_TO_IE       = 1;  // time-out interrupt enable
    localparam int          BIT_PIN_SEL     = 0;  // pin34_output_select
    localparam int          BIT_ALT_RUN     = 6;  // duplicate enable in alternate reg
    localparam int          BIT_DEMOD       = 7;  // mode bit in common reg
    localparam logic [7:0]  KEEP_MASK       = 8'h1e; // fields kept through recovery

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0]  RST_CTRL        = 8'h00;
    localparam logic [7:0]  RST_ALT         = 8'h00;
    localparam logic [7:0]  RST_COMMON      = 8'h00;
    localparam logic [7:0]  RST_RELOAD      = 8'h00;
    localparam logic [2:0]  RST_DIV         = 3'h0;
    localparam logic [7:0]  TERMINAL        = 8'h00;

endpackage

// ==== core/ett_timer.sv ====
// eight-bit timer control block with its axi4-lite register slave
`timescale 1ns/1ps
module ett_timer (
    input  wire logic                        clk_sys_i,
    input  wire logic                        rstn_i,
    // axi4-lite slave
    input  wire logic [ett_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
    input  wire logic                        s_axi_awvalid_i,
    output logic                             s_axi_awready_o,
    input  wire logic [ett_pkg::DATA_W-1:0]  s_axi_wdata_i,
    input  wire logic [3:0]                  s_axi_wstrb_i,
    input  wire logic                        s_axi_wvalid_i,
    output logic                             s_axi_wready_o,
    output logic [1:0]                       s_axi_bresp_o,
    output logic                             s_axi_bvalid_o,
    input  wire logic                        s_axi_bready_i,
    input  wire logic [ett_pkg::ADDR_W-1:0]  s_axi_araddr_i,
    input  wire logic                        s_axi_arvalid_i,
    output logic                             s_axi_arready_o,
    output logic [ett_pkg::DATA_W-1:0]       s_axi_rdata_o,
    output logic [1:0]                       s_axi_rresp_o,
    output logic                             s_axi_rvalid_o,
    input  wire logic                        s_axi_rready_i,
    // neighbouring logic on the same clock
    input  wire logic                        capture_event_i,
    input  wire logic                        stop_recovery_i,
    input  wire logic                        port_latch_i,
    output logic                             capture_irq_o,
    output logic                             timeout_irq_o,
    output logic                             timer_out_o,
    output logic                             port3_pin4_o
);
    import ett_pkg::*;

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0]        ctrl;
        logic [7:0]        alt;
        logic [7:0]        common;
        logic [7:0]        reload;
        logic [7:0]        count;
        logic              halted;
        logic              tout_level;
        logic [2:0]        div;
        logic              aw_got;
        logic [ADDR_W-1:0] awaddr;
        logic              w_got;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        wstrb;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0]        rresp;
        logic              cap_irq;
        logic              to_irq;
        logic              pin;
    } ett_state_s;

    localparam ett_state_s RST_STATE = '{
        ctrl: RST_CTRL, alt: RST_ALT, common: RST_COMMON, reload: RST_RELOAD,
        count: RST_RELOAD, div: RST_DIV, rresp: RESP_OKAY, bresp: RESP_OKAY,
        default: '0
    };

    ett_state_s        st;
    ett_state_s        next_st;
    logic [1:0]        rst_sync;
    logic              rst_n;

    // ****************************************************************
    // helpers
    // ****************************************************************

    // true when an address names a mapped register
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a == OFF_CTRL) || (a == OFF_ALT) || (a == OFF_COMMON) ||
                    (a == OFF_RELOAD) || (a == OFF_COUNT) || (a == OFF_STATUS);
    endfunction

    // one tick every 2**sel cycles of the free divider
    function automatic logic div_tick(input logic [2:0] d, input logic [1:0] sel);
        logic [2:0] mask;
        mask = 3'h0;
        unique case (sel)
            2'h0: mask = 3'h0;
            2'h1: mask = 3'h1;
            2'h2: mask = 3'h3;
            2'h3: mask = 3'h7;
        endcase
        div_tick = ((d & mask) == mask);
    endfunction

    // ****************************************************************
    // reset release
    // ****************************************************************

    // release is synchronised so no flop leaves reset on a split edge
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ****************************************************************
    // combinational decode
    // ****************************************************************
    logic              run;
    logic              tick;
    logic              tc_event;
    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr_lane0;

    assign run      = st.ctrl[BIT_RUN] | st.alt[BIT_ALT_RUN];
    assign tick     = div_tick(st.div, st.ctrl[BIT_PRE_HI:BIT_PRE_LO]);
    assign tc_event = run && !st.halted && tick && (st.count == TERMINAL);

    // bus handshakes; both write halves wait while a response is pending
    assign s_axi_awready_o = !st.aw_got && !st.bvalid;
    assign s_axi_wready_o  = !st.w_got && !st.bvalid;
    assign s_axi_arready_o = !st.rvalid;
    assign aw_hs           = s_axi_awvalid_i && s_axi_awready_o;
    assign w_hs            = s_axi_wvalid_i && s_axi_wready_o;
    assign ar_hs           = s_axi_arvalid_i && s_axi_arready_o;
    assign wr_en           = (st.aw_got || aw_hs) && (st.w_got || w_hs);
    assign wr_addr         = st.aw_got ? st.awaddr : s_axi_awaddr_i;
    assign wr_data         = st.w_got ? st.wdata : s_axi_wdata_i;
    assign wr_lane0        = st.w_got ? st.wstrb[0] : s_axi_wstrb_i[0];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st         = st;
        next_st.cap_irq = 1'b0;
        next_st.to_irq  = 1'b0;

        // divider never stops, so a prescale change only moves the next tick
        next_st.div = st.div + 3'h1;

        // counter: held at its initial value while stopped
        if (!run) begin
            next_st.count  = st.reload;
            next_st.halted = 1'b0;
        end else if (!st.halted && tick) begin
            if (st.count == TERMINAL) begin
                next_st.tout_level = !st.tout_level;
                if (st.ctrl[BIT_ONE_SHOT]) begin
                    next_st.halted = 1'b1;
                end else begin
                    next_st.count = st.reload;
                end
            end else begin
                next_st.count = st.count - 8'h01;
            end
        end

        // write channel capture
        if (aw_hs) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr_i;
        end
        if (w_hs) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata_i;
            next_st.wstrb = s_axi_wstrb_i;
        end

        // register write; only byte lane 0 carries register bits
        if (wr_en) begin
            next_st.aw_got = 1'b0;
            next_st.w_got  = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp  = is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
            if (wr_lane0) begin
                unique case (wr_addr)
                    OFF_CTRL: begin
                        next_st.ctrl[7:6] = wr_data[7:6];
                        next_st.ctrl[4:0] = wr_data[4:0];
                        if (wr_data[BIT_TIMEOUT]) begin
                            next_st.ctrl[BIT_TIMEOUT] = 1'b0;
                        end
                    end
                    OFF_ALT:    next_st.alt    = wr_data[7:0];
                    OFF_COMMON: next_st.common = wr_data[7:0];
                    OFF_RELOAD: next_st.reload = wr_data[7:0];
                    default:    next_st.bresp  = next_st.bresp;
                endcase
            end
        end
        if (st.bvalid && s_axi_bready_i) begin
            next_st.bvalid = 1'b0;
        end

        // register read
        if (ar_hs) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = is_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
            unique case (s_axi_araddr_i)
                OFF_CTRL:   next_st.rdata = {24'h0, st.ctrl};
                OFF_ALT:    next_st.rdata = {24'h0, st.alt};
                OFF_COMMON: next_st.rdata = {24'h0, st.common};
                OFF_RELOAD: next_st.rdata = {24'h0, st.reload};
                OFF_COUNT:  next_st.rdata = {24'h0, st.count};
                OFF_STATUS: next_st.rdata = {28'h0, st.pin, st.tout_level,
                                             st.halted, run};
                default:    next_st.rdata = 32'h0;
            endcase
        end else if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end

        // stop recovery clears control, alternate and common registers except prescale and the two interrupt enables
        if (stop_recovery_i) begin
            next_st.ctrl   = (next_st.ctrl & KEEP_MASK) | (RST_CTRL & ~KEEP_MASK);
            next_st.alt    = RST_ALT;
            next_st.common = RST_COMMON;
        end

        // flag set beats a same-cycle clear so no time-out is lost
        if (tc_event) begin
            next_st.ctrl[BIT_TIMEOUT] = 1'b1;
            next_st.to_irq            = st.ctrl[BIT_TO_IE];
        end

        // capture interrupts only exist in demodulation operation
        next_st.cap_irq = capture_event_i && st.ctrl[BIT_CAP_IE] &&
                          st.common[BIT_DEMOD];

        // pin routing, registered so the pin never glitches
        next_st.pin = st.ctrl[BIT_PIN_SEL] ? st.tout_level : port_latch_i;
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o  = st.bresp;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rdata_o  = st.rdata;
    assign s_axi_rresp_o  = st.rresp;
    assign capture_irq_o  = st.cap_irq;
    assign timeout_irq_o  = st.to_irq;
    assign timer_out_o    = st.tout_level;
    assign port3_pin4_o   = st.pin;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n);

    sequence s_terminal;
        run && !st.halted && tick && (st.count == TERMINAL);
    endsequence

    sequence s_ctrl_write_one;
        wr_en && wr_lane0 && (wr_addr == OFF_CTRL) && wr_data[BIT_TIMEOUT];
    endsequence

    stopped_holds_a: assert property (
        !run ##1 !run |-> st.count == $past(st.reload))
        else $error("count left its initial value while stopped");

    reload_mode_a: assert property (
        (s_terminal and !st.ctrl[BIT_ONE_SHOT]) |=> st.count == $past(st.reload))
        else $error("reload mode did not reload at terminal count");

    one_shot_halt_a: assert property (
        (s_terminal and st.ctrl[BIT_ONE_SHOT]) |=> st.halted && $stable(st.count))
        else $error("one-shot mode did not halt at terminal count");

    flag_sets_a: assert property (
        s_terminal |=> st.ctrl[BIT_TIMEOUT])
        else $error("terminal count did not set the time-out flag");

    flag_clears_a: assert property (
        (s_ctrl_write_one and !tc_event) |=> !st.ctrl[BIT_TIMEOUT])
        else $error("writing one did not clear the time-out flag");

    // the next tick lands on the eighth edge after the last one, not the seventh
    divide_eight_a: assert property (
        (tick && st.ctrl[4:3] == 2'h3) ##1 (st.ctrl[4:3] == 2'h3)[*8] |-> tick)
        else $error("divide by eight tick spacing wrong");

    divide_two_a: assert property (
        (tick && st.ctrl[4:3] == 2'h1) ##1 (st.ctrl[4:3] == 2'h1)[*2] |-> tick)
        else $error("divide by two tick spacing wrong");

    keep_fields_a: assert property (
        stop_recovery_i && !wr_en |=> (st.ctrl & KEEP_MASK) == ($past(st.ctrl) & KEEP_MASK))
        else $error("kept fields changed on stop recovery");

    capture_irq_a: assert property (
        capture_irq_o |-> $past(capture_event_i) && $past(st.ctrl[BIT_CAP_IE]) &&
                          $past(st.common[BIT_DEMOD]))
        else $error("capture interrupt without enabled capture");

    // the forward half: an enabled capture in demodulation always interrupts
    capture_fire_a: assert property (
        capture_event_i && st.ctrl[BIT_CAP_IE] && st.common[BIT_DEMOD] |=> capture_irq_o)
        else $error("enabled capture gave no interrupt");

    timeout_irq_a: assert property (
        s_terminal |=> timeout_irq_o == $past(st.ctrl[BIT_TO_IE]))
        else $error("time-out interrupt does not follow its enable");

    pin_route_a: assert property (
        ##1 port3_pin4_o == ($past(st.ctrl[BIT_PIN_SEL]) ? $past(st.tout_level)
                                                         : $past(port_latch_i)))
        else $error("pin shows the wrong source");

    // bus answers: one cycle after the write or read is taken
    write_ok_a: assert property (
        wr_en && is_mapped(wr_addr) |=> s_axi_bvalid_o && (s_axi_bresp_o == RESP_OKAY))
        else $error("no okay response after a mapped write");

    write_err_a: assert property (
        wr_en && !is_mapped(wr_addr) |=> s_axi_bvalid_o && (s_axi_bresp_o == RESP_SLVERR))
        else $error("no error response after an unmapped write");

    read_resp_a: assert property (
        ar_hs |=> s_axi_rvalid_o)
        else $error("no read answer after a taken read address");

endmodule

// ==== verification/eight_bit_timer_control_test.sv ====
// self-checking testbench for the eight-bit timer control block
`timescale 1ns/1ps
`define ETT_CHK(what, exp, got) \
    begin \
        total_checks++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("FAIL %s expected %h seen %h", what, exp, got); \
        end \
    end
module eight_bit_timer_control_test;
    import ett_pkg::*;
    typedef struct {
        logic [DATA_W-1:0] data;
        logic [DATA_W-1:0] mask;
        logic [1:0]        resp;
    } ett_exp_s;
    localparam int LIMIT = 20000; // generous against well under 1000 cycles of traffic
    logic              clk, rstn, awvalid, wvalid, bready, arvalid, rready;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    logic              cap_ev, stop_rec, port_latch, cap_irq, to_irq, t_out, pin;
    ett_exp_s          exp_r[$];
    logic [1:0]        exp_b[$];
    ett_exp_s          er;
    logic [1:0]        eb;
    int                miscompares, total_checks, cycles, to_cnt, cap_cnt, n, c0;
    logic [7:0]        init, v, prev;

    ett_timer u_dut (
        .clk_sys_i(clk), .rstn_i(rstn),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .capture_event_i(cap_ev), .stop_recovery_i(stop_rec), .port_latch_i(port_latch),
        .capture_irq_o(cap_irq), .timeout_irq_o(to_irq), .timer_out_o(t_out),
        .port3_pin4_o(pin)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************************************
    // watcher: bus answers against the oldest note, irq pulses, hang cut
    // ****************************************************************
    always @(posedge clk) begin
        cycles++;
        if (to_irq === 1'b1) to_cnt++;
        if (cap_irq === 1'b1) cap_cnt++;
        if (bvalid && bready && exp_b.size() > 0) begin
            eb = exp_b.pop_front();
            `ETT_CHK("write response", eb, bresp)
        end
        if (rvalid && rready && exp_r.size() > 0) begin
            er = exp_r.pop_front();
            `ETT_CHK("read response", er.resp, rresp)
            `ETT_CHK("read data", er.data & er.mask, rdata & er.mask)
        end
        if (cycles == LIMIT) begin
            miscompares++;
            give_verdict();
        end
    end

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      input logic [1:0] r, input logic [3:0] s = 4'hf);
        logic aw_ok;
        logic w_ok;
        @(posedge clk);
        exp_b.push_back(r);
        awaddr  <= a;
        wdata   <= {24'($urandom()), d}; // upper lanes must be ignored
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [DATA_W-1:0] m, input logic [1:0] r);
        @(posedge clk);
        exp_r.push_back('{data: d, mask: m, resp: r});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (!(arvalid && arready));
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask

    // cycles from the previous timeout pulse to the next one
    task automatic wait_to(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (to_irq !== 1'b1);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {cap_ev, stop_rec, port_latch} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        void'($urandom(72926));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, then the flag cleared before any use
        rd(OFF_CTRL, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(OFF_ALT, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(OFF_COMMON, 32'h0, 32'hffffffff, RESP_OKAY);
        wr(OFF_CTRL, 8'h20, RESP_OKAY);
        // lane 0 off stores nothing; unmapped places answer with an error
        wr(OFF_RELOAD, 8'h55, RESP_OKAY, 4'he);
        rd(OFF_RELOAD, 32'h0, 32'hffffffff, RESP_OKAY);
        wr(5'h18, 8'hff, RESP_SLVERR);
        rd(5'h1c, 32'h0, 32'hffffffff, RESP_SLVERR);
        // either enable bit runs the counter, both low stop it
        for (int k = 0; k < 4; k++) begin
            wr(OFF_ALT, {1'b0, k[0], 6'h0}, RESP_OKAY);
            wr(OFF_CTRL, {k[1], 7'h0}, RESP_OKAY);
            rd(OFF_STATUS, {31'h0, k[0] | k[1]}, 32'h1, RESP_OKAY);
        end
        wr(OFF_ALT, 8'h0, RESP_OKAY);
        // reload period for every prescale choice, random initial value
        for (int s = 0; s < 4; s++) begin
            init = 8'($urandom_range(9, 1));
            wr(OFF_RELOAD, init, RESP_OKAY);
            wr(OFF_CTRL, {3'h4, 2'(s), 3'h2}, RESP_OKAY);
            wait_to(n);
            wait_to(n);
            `ETT_CHK("reload period", (int'(init) + 1) << s, n)
        end
        rd(OFF_CTRL, 32'h20, 32'h20, RESP_OKAY);
        wr(OFF_CTRL, 8'h00, RESP_OKAY);
        rd(OFF_CTRL, 32'h20, 32'h20, RESP_OKAY);
        wr(OFF_CTRL, 8'h20, RESP_OKAY);
        rd(OFF_CTRL, 32'h00, 32'h20, RESP_OKAY);
        // time-out interrupt masked: flag still sets, no pulse
        wr(OFF_RELOAD, 8'h01, RESP_OKAY);
        c0 = to_cnt;
        wr(OFF_CTRL, 8'h80, RESP_OKAY);
        repeat (20) @(posedge clk);
        `ETT_CHK("masked timeout pulses", 0, to_cnt - c0)
        rd(OFF_CTRL, 32'h20, 32'h20, RESP_OKAY);
        // one-shot stops at terminal count after exactly one time-out
        wr(OFF_CTRL, 8'h20, RESP_OKAY);
        wr(OFF_RELOAD, 8'h03, RESP_OKAY);
        c0 = to_cnt;
        wr(OFF_CTRL, 8'hc2, RESP_OKAY);
        repeat (40) @(posedge clk);
        `ETT_CHK("one-shot pulses", 1, to_cnt - c0)
        rd(OFF_STATUS, 32'h2, 32'h2, RESP_OKAY);
        rd(OFF_COUNT, 32'h0, 32'hffffffff, RESP_OKAY);
        // capture interrupt needs its enable and demodulation mode
        for (int k = 0; k < 4; k++) begin
            wr(OFF_COMMON, {k[1], 7'h0}, RESP_OKAY);
            wr(OFF_CTRL, {5'h0, k[0], 2'h0}, RESP_OKAY);
            c0 = cap_cnt;
            @(posedge clk);
            cap_ev <= 1'b1;
            @(posedge clk);
            cap_ev <= 1'b0;
            repeat (3) @(posedge clk);
            `ETT_CHK("capture pulses", int'(k[0] & k[1]), cap_cnt - c0)
        end
        // pin shows the latch value driven two edges earlier, then the timer output
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            if (k > 1) `ETT_CHK("pin from latch", prev[1], pin)
            prev = {prev[6:0], 1'($urandom())};
            port_latch <= prev[0];
        end
        wr(OFF_CTRL, 8'h01, RESP_OKAY);
        repeat (3) @(posedge clk);
        `ETT_CHK("pin from timer", t_out, pin)
        // stop recovery keeps only prescale and the two interrupt enables of the three control registers
        v = 8'($urandom());
        // a long initial value keeps a terminal count out of this window
        wr(OFF_RELOAD, 8'hff, RESP_OKAY);
        wr(OFF_ALT, 8'h40, RESP_OKAY);
        wr(OFF_COMMON, 8'h80, RESP_OKAY);
        wr(OFF_CTRL, v, RESP_OKAY);
        @(posedge clk);
        stop_rec <= 1'b1;
        @(posedge clk);
        stop_rec <= 1'b0;
        rd(OFF_CTRL, {24'h0, v & KEEP_MASK}, 32'hffffffff, RESP_OKAY);
        rd(OFF_ALT, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(OFF_COMMON, 32'h0, 32'hffffffff, RESP_OKAY);
        rd(OFF_RELOAD, 32'hff, 32'hffffffff, RESP_OKAY);
        repeat (4) @(posedge clk);
        give_verdict();
    end
endmodule
